// *** logic/ec_ocr_pkg.sv ***
// Shared constants for the mirror control and over-current recovery block
package ec_ocr_pkg;
   // Serial frame layout: write flag, address, data word
   localparam int FRAME_BITS = 24;
   localparam int ADDR_BITS = 7;
   localparam int DATA_BITS = 16;
   localparam int WRITE_FLAG_POS = 23;
   localparam int ADDR_LSB = 16;
   // Register addresses
   localparam logic [6:0] EC_AND_OUTPUT_CONTROL_ADDR = 7'h02;
   localparam logic [6:0] OVERCURRENT_RECOVERY_CONTROL_ADDR = 7'h03;
   localparam logic [6:0] OVERCURRENT_STATUS_ADDR = 7'h10;
   // Reset values
   localparam logic [15:0] EC_AND_OUTPUT_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] OVERCURRENT_RECOVERY_CONTROL_RESET = 16'h0000;
   // Writable bit masks; reserved bits never store and read zero
   localparam logic [15:0] EC_AND_OUTPUT_CONTROL_MASK = 16'hfffe;
   localparam logic [15:0] OVERCURRENT_RECOVERY_CONTROL_MASK = 16'hfeff;
   // Fields of the mirror and output control register
   localparam int EC_CODE_MSB = 7;
   localparam int EC_CODE_LSB = 2;
   localparam int EC_MODE_POS = 1;
   localparam int HIGHSIDE_TEN_POS = 10;
   localparam int EC_DISCHARGE_POS = 8;
   // Fields of the recovery control register
   localparam int RECOVERY_ONE_POS = 15;
   localparam int RECOVERY_TWO_POS = 14;
   localparam int RECOVERY_THREE_POS = 13;
   localparam int RECOVERY_EC_POS = 9;
   localparam int FULL_SCALE_POS = 0;
   // Channel indices in the status word
   localparam int CHANNELS = 4;
   localparam int CH_ONE = 0;
   localparam int CH_TWO = 1;
   localparam int CH_THREE = 2;
   localparam int CH_EC = 3;
   // Recovery off times and clock rate
   localparam int CLOCK_MHZ = 250;
   localparam int OFF_SHORT_NS = 10000;
   localparam int OFF_LONG_NS = 40000;
   localparam int OFF_SHORT_CYCLES = OFF_SHORT_NS * CLOCK_MHZ / 1000;
   localparam int OFF_LONG_CYCLES = OFF_LONG_NS * CLOCK_MHZ / 1000;
   localparam int COUNT_BITS = 16;
endpackage : ec_ocr_pkg

// *** logic/overcurrent_channel.sv ***
// One output path with over-current trip and timed recovery
`timescale 1ns/100ps
`default_nettype none
module overcurrent_channel (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic request,
   input wire logic overcurrent,
   input wire logic recovery_enable,
   input wire logic [15:0] off_cycles,
   output logic drive,
   output logic trip
);
   // Channel state
   typedef enum logic {running, tripped} channel_state_type;
   channel_state_type state_reg;
   logic [15:0] wait_reg; // Remaining off time

   // Trip, wait and re-enable sequence
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= running;
         wait_reg <= 16'h0000;
         drive <= 1'b0;
         trip <= 1'b0;
      end else if (clk_en) begin
         trip <= 1'b0;
         unique case (state_reg)
            running: begin
               // Switch off at once on a fault while driven
               if (overcurrent && drive) begin
                  drive <= 1'b0;
                  trip <= 1'b1;
                  state_reg <= tripped;
                  wait_reg <= off_cycles;
               end else begin
                  drive <= request;
               end
            end
            tripped: begin
               drive <= 1'b0;
               if (!request) begin
                  // Dropped request ends the latch-off
                  state_reg <= running;
               end else if (recovery_enable) begin
                  // Repeated trips give a pulsed current
                  if (wait_reg <= 16'h0001) begin
                     state_reg <= running;
                  end else begin
                     wait_reg <= wait_reg - 16'h0001;
                  end
               end
            end
         endcase
      end
   end
endmodule : overcurrent_channel
`default_nettype wire

// *** logic/ec_mirror_and_ocr_control.sv ***
// Mirror control register bank with serial access and over-current recovery
// Function
// - Bits 7..2 form six-bit reference code
// - Full scale chosen by second register bit
// - All-zero code commands zero target voltage
// - Discharge bit turns on sense-pin lowside
// - Mode bit enables mode and gate driver
// - Mode forces highside ten on, ignoring bit
// - Over-current sets flag, switches output off
// - Per-output recovery bits re-enable after delay
// - Recovery duty chosen by external select bit
// - One extra recovery cycle may occur
// - Mode disables recovery on sense output
`timescale 1ns/100ps
`default_nettype none
module ec_mirror_and_ocr_control #(
   parameter int OFF_LONG = ec_ocr_pkg::OFF_LONG_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso_out,
   output logic spi_miso_oe_n,
   input wire logic [2:0] bridge_request,
   input wire logic [3:0] overcurrent_in,
   input wire logic duty_select,
   output logic bridge_output_one,
   output logic bridge_output_two,
   output logic bridge_output_three,
   output logic ec_fast_discharge_switch,
   output logic highside_ten,
   output logic ec_gate_drive_pin,
   output logic [5:0] ec_reference_code,
   output logic ec_target_zero,
   output logic ec_full_scale_select,
   output logic [3:0] overcurrent_flags
);
   // Register storage
   logic [15:0] ec_and_output_control_reg;
   logic [15:0] overcurrent_recovery_control_reg;
   // Pin synchronisers, second stage is the only reader of the first
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   logic sclk_last_reg; // Previous synced clock for edge detect
   logic [3:0] oc_meta_reg;
   logic [3:0] oc_sync_reg;
   // Serial frame state
   logic [4:0] bit_count_reg;
   logic [23:0] shift_in_reg;
   logic [15:0] shift_out_reg;
   logic cs_n_s;
   logic sclk_s;
   logic sclk_rise;
   logic sclk_fall;
   logic frame_end;
   logic [23:0] frame_next; // Frame including the current bit
   // Channel wiring
   logic [3:0] channel_request;
   logic [3:0] channel_recovery;
   logic [3:0] channel_drive;
   logic [3:0] channel_trip;
   logic [15:0] off_cycles;
   logic ec_mode;

   // Register read mux, used for the shift load and nowhere else twice
   function automatic logic [15:0] read_word(input logic [6:0] addr);
      unique case (addr)
         ec_ocr_pkg::EC_AND_OUTPUT_CONTROL_ADDR: read_word = ec_and_output_control_reg;
         ec_ocr_pkg::OVERCURRENT_RECOVERY_CONTROL_ADDR:
            read_word = overcurrent_recovery_control_reg;
         ec_ocr_pkg::OVERCURRENT_STATUS_ADDR: read_word = {12'h000, overcurrent_flags};
         default: read_word = 16'h0000; // Unmapped reads zero
      endcase
   endfunction : read_word

   // Two-stage synchronisers for pins and analog fault comparators
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_meta_reg <= 3'h1;
         pin_sync_reg <= 3'h1;
         sclk_last_reg <= 1'b0;
         oc_meta_reg <= 4'h0;
         oc_sync_reg <= 4'h0;
      end else if (clk_en) begin
         pin_meta_reg <= {spi_mosi, spi_sclk, spi_cs_n};
         pin_sync_reg <= pin_meta_reg;
         sclk_last_reg <= pin_sync_reg[1];
         oc_meta_reg <= overcurrent_in;
         oc_sync_reg <= oc_meta_reg;
      end
   end

   assign cs_n_s = pin_sync_reg[0];
   assign sclk_s = pin_sync_reg[1];
   assign sclk_rise = !cs_n_s && sclk_s && !sclk_last_reg;
   assign sclk_fall = !cs_n_s && !sclk_s && sclk_last_reg;
   assign frame_next = {shift_in_reg[22:0], pin_sync_reg[2]};
   // Frame takes effect on the 24th rising edge, and again on every 24th edge after it
   assign frame_end = sclk_rise && (bit_count_reg == 5'h17);

   // Serial shifter, MSB first, sample on rising clock
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bit_count_reg <= 5'h00;
         shift_in_reg <= 24'h000000;
      end else if (clk_en) begin
         if (cs_n_s) begin
            bit_count_reg <= 5'h00;
         end else if (sclk_rise) begin
            shift_in_reg <= frame_next;
            // Longer frames wrap, so each further 24 bits commit as a new frame
            bit_count_reg <= (bit_count_reg == 5'h17) ? 5'h00 : bit_count_reg + 5'h01;
         end
      end
   end

   // Read data loads after the address byte, shifts out on falling clock
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         shift_out_reg <= 16'h0000;
         spi_miso_out <= 1'b0;
         spi_miso_oe_n <= 1'b1;
      end else if (clk_en) begin
         spi_miso_oe_n <= cs_n_s;
         if (sclk_rise && bit_count_reg == 5'h07) begin
            shift_out_reg <= read_word(frame_next[6:0]);
         end else if (sclk_fall && bit_count_reg >= 5'h08) begin
            spi_miso_out <= shift_out_reg[15];
            shift_out_reg <= {shift_out_reg[14:0], 1'b0};
         end
      end
   end

   // Control register writes; reserved bits are masked off
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ec_and_output_control_reg <= ec_ocr_pkg::EC_AND_OUTPUT_CONTROL_RESET;
         overcurrent_recovery_control_reg <= ec_ocr_pkg::OVERCURRENT_RECOVERY_CONTROL_RESET;
      end else if (clk_en && frame_end && frame_next[ec_ocr_pkg::WRITE_FLAG_POS]) begin
         // Software is expected to send zeros there anyway
         if (frame_next[22:16] == ec_ocr_pkg::EC_AND_OUTPUT_CONTROL_ADDR) begin
            ec_and_output_control_reg <=
               frame_next[15:0] & ec_ocr_pkg::EC_AND_OUTPUT_CONTROL_MASK;
         end
         if (frame_next[22:16] == ec_ocr_pkg::OVERCURRENT_RECOVERY_CONTROL_ADDR) begin
            overcurrent_recovery_control_reg <=
               frame_next[15:0] & ec_ocr_pkg::OVERCURRENT_RECOVERY_CONTROL_MASK;
         end
      end
   end

   // Sticky fault flags: write one to clear, a new trip wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         overcurrent_flags <= 4'h0;
      end else if (clk_en) begin
         if (frame_end && frame_next[ec_ocr_pkg::WRITE_FLAG_POS]
             && frame_next[22:16] == ec_ocr_pkg::OVERCURRENT_STATUS_ADDR) begin
            overcurrent_flags <= (overcurrent_flags & ~frame_next[3:0]) | channel_trip;
         end else begin
            overcurrent_flags <= overcurrent_flags | channel_trip;
         end
      end
   end

   assign ec_mode = ec_and_output_control_reg[ec_ocr_pkg::EC_MODE_POS];
   // Duty select picks the off time of every recovering output
   assign off_cycles = duty_select ? ec_ocr_pkg::OFF_SHORT_CYCLES[15:0] : OFF_LONG[15:0];
   assign channel_request = {ec_and_output_control_reg[ec_ocr_pkg::EC_DISCHARGE_POS],
                             bridge_request};
   assign channel_recovery = {
      overcurrent_recovery_control_reg[ec_ocr_pkg::RECOVERY_EC_POS] && !ec_mode,
      overcurrent_recovery_control_reg[ec_ocr_pkg::RECOVERY_THREE_POS],
      overcurrent_recovery_control_reg[ec_ocr_pkg::RECOVERY_TWO_POS],
      overcurrent_recovery_control_reg[ec_ocr_pkg::RECOVERY_ONE_POS]};

   // One trip and recovery path per protected output
   for (genvar i = 0; i < ec_ocr_pkg::CHANNELS; i++) begin : g_channel
      overcurrent_channel u_channel (
         .clk(clk),
         .reset(reset),
         .clk_en(clk_en),
         .request(channel_request[i]),
         .overcurrent(oc_sync_reg[i]),
         .recovery_enable(channel_recovery[i]),
         .off_cycles(off_cycles),
         .drive(channel_drive[i]),
         .trip(channel_trip[i])
      );
   end

   // Output drivers, all from flops
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bridge_output_one <= 1'b0;
         bridge_output_two <= 1'b0;
         bridge_output_three <= 1'b0;
         ec_fast_discharge_switch <= 1'b0;
         highside_ten <= 1'b0;
         ec_gate_drive_pin <= 1'b0;
      end else if (clk_en) begin
         bridge_output_one <= channel_drive[ec_ocr_pkg::CH_ONE];
         bridge_output_two <= channel_drive[ec_ocr_pkg::CH_TWO];
         bridge_output_three <= channel_drive[ec_ocr_pkg::CH_THREE];
         ec_fast_discharge_switch <= channel_drive[ec_ocr_pkg::CH_EC];
         // Mode overrides the highside bit so supply current can be sensed
         highside_ten <= ec_mode
            || ec_and_output_control_reg[ec_ocr_pkg::HIGHSIDE_TEN_POS];
         ec_gate_drive_pin <= ec_mode;
      end
   end

   // Reference code and full scale toward the amplifier
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ec_reference_code <= 6'h00;
         ec_target_zero <= 1'b1;
         ec_full_scale_select <= 1'b0;
      end else if (clk_en) begin
         ec_reference_code <= ec_and_output_control_reg[ec_ocr_pkg::EC_CODE_MSB:
                                                        ec_ocr_pkg::EC_CODE_LSB];
         ec_target_zero <= ec_and_output_control_reg[ec_ocr_pkg::EC_CODE_MSB:
                                                     ec_ocr_pkg::EC_CODE_LSB] == 6'h00;
         ec_full_scale_select <=
            overcurrent_recovery_control_reg[ec_ocr_pkg::FULL_SCALE_POS];
      end
   end
endmodule : ec_mirror_and_ocr_control
`default_nettype wire

// *** test/spi_master_model.sv ***
// Serial master standing in for the controlling microcontroller
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
   input wire logic clk,
   input wire logic miso,
   output logic cs_n,
   output logic sclk,
   output logic mosi
);
   // Idle bus: deselected, clock parked low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // One 24-bit frame, MSB first; half period of 8 clk clears the sync
   task automatic xfer(input logic [23:0] f, output logic [15:0] q);
      q = 16'h0000;
      @(negedge clk) cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         mosi = f[i];
         repeat (8) @(negedge clk);
         sclk = 1'b1;
         // Data bits arrive during the last 16 pulses
         if (i < 16) begin
            q = {q[14:0], miso};
         end
         repeat (8) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (8) @(negedge clk);
      cs_n = 1'b1;
      // Released data line must not look held
      mosi = ~mosi;
      repeat (8) @(negedge clk);
   endtask : xfer
endmodule : spi_master_model
`default_nettype wire

// *** test/ec_mirror_and_ocr_control_checker.sv ***
// Port checks for the mirror control and recovery block
`timescale 1ns/100ps
`default_nettype none
module ec_ocr_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic spi_cs_n,
   input wire logic bridge_output_one,
   input wire logic bridge_output_two,
   input wire logic ec_fast_discharge_switch,
   input wire logic highside_ten,
   input wire logic ec_gate_drive_pin,
   input wire logic [5:0] ec_reference_code,
   input wire logic ec_target_zero,
   input wire logic [3:0] overcurrent_flags
);
   logic [3:0] idle_reg; // Quiet bus cycles, saturating
   // Any frame restarts the count, so a clear can never look quiet
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         idle_reg <= 4'h0;
      end else if (spi_cs_n) begin
         idle_reg <= idle_reg + {3'h0, idle_reg != 4'hf};
      end else begin
         idle_reg <= 4'h0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_ten_forced: assert property (ec_gate_drive_pin |-> highside_ten)
      else $error("highside ten off in mirror mode");
   a_zero_code: assert property (ec_target_zero == (ec_reference_code == 6'h00))
      else $error("zero target flag disagrees with code");
   a_mode_by_frame: assert property ($changed(ec_gate_drive_pin) |-> !spi_cs_n)
      else $error("gate drive changed outside a frame");
   a_trip_one: assert property ($rose(overcurrent_flags[0]) |-> $past(bridge_output_one))
      else $error("flag one set while output one idle");
   a_recover_delay: assert property ($rose(overcurrent_flags[0]) |-> !bridge_output_one [*8])
      else $error("output one back too soon");
   a_trip_two_edge: assert property ($rose(overcurrent_flags[1]) |->
      $past(bridge_output_two) && !bridge_output_two) else $error("output two not cut");
   a_ec_trip_off: assert property ($rose(overcurrent_flags[3]) |->
      $past(ec_fast_discharge_switch) && !ec_fast_discharge_switch) else $error("lowside not cut");
   a_flag_sticky: assert property (idle_reg == 4'hf |->
      !(|($past(overcurrent_flags) & ~overcurrent_flags))) else $error("flag dropped on idle bus");
endmodule : ec_ocr_checker
bind ec_mirror_and_ocr_control ec_ocr_checker chk_i (.clk, .reset, .spi_cs_n,
   .bridge_output_one, .bridge_output_two, .ec_fast_discharge_switch, .highside_ten,
   .ec_gate_drive_pin, .ec_reference_code, .ec_target_zero, .overcurrent_flags);
`default_nettype wire

// *** test/ec_mirror_and_ocr_control_bench.sv ***
// Self-checking bench for the mirror control and recovery block
`timescale 1ns/100ps
`default_nettype none
module ec_mirror_and_ocr_control_bench;
   localparam int OFF = 40; // Shortened long off time
   localparam logic [6:0] A_EC = ec_ocr_pkg::EC_AND_OUTPUT_CONTROL_ADDR;
   localparam logic [6:0] A_RC = ec_ocr_pkg::OVERCURRENT_RECOVERY_CONTROL_ADDR;
   localparam int SHORT = ec_ocr_pkg::OFF_SHORT_CYCLES;
   typedef struct packed {logic [15:0] data; logic [9:0] outs;} row_type;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1; // Frozen once, late in the run
   logic [2:0] bridge_request = 3'h0;
   logic [3:0] overcurrent_in = 4'h0;
   logic duty_select = 1'b0;
   logic spi_cs_n, spi_sclk, spi_mosi, spi_miso_out, spi_miso_oe_n, miso_line;
   logic bridge_output_one, bridge_output_two, bridge_output_three;
   logic ec_fast_discharge_switch, highside_ten, ec_gate_drive_pin;
   logic ec_target_zero, ec_full_scale_select;
   logic [5:0] ec_reference_code;
   logic [3:0] overcurrent_flags, outs_w;
   int mismatches = 0;
   int n_compared = 0;
   // Rows: written word, then {code, zero, ten, gate, discharge}
   row_type rows [5] = '{'{16'h00fc, 10'h3f0}, '{16'h0400, 10'h00c},
      '{16'h0106, 10'h017}, '{16'h0080, 10'h200}, '{16'h0000, 10'h008}};
   always #2 clk = ~clk;
   // Released line toggles so a stale bit never passes
   assign miso_line = spi_miso_oe_n ? clk : spi_miso_out;
   assign outs_w = {ec_fast_discharge_switch, bridge_output_three, bridge_output_two,
      bridge_output_one};
   ec_mirror_and_ocr_control #(.OFF_LONG(OFF)) DUT (.clk, .reset, .clk_en, .spi_cs_n,
      .spi_sclk, .spi_mosi, .spi_miso_out, .spi_miso_oe_n, .bridge_request,
      .overcurrent_in, .duty_select, .bridge_output_one, .bridge_output_two,
      .bridge_output_three, .ec_fast_discharge_switch, .highside_ten, .ec_gate_drive_pin,
      .ec_reference_code, .ec_target_zero, .ec_full_scale_select, .overcurrent_flags);
   spi_master_model sm (.clk, .miso(miso_line), .cs_n(spi_cs_n), .sclk(spi_sclk),
      .mosi(spi_mosi));
   // Word compare
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Cycle count compare
   task automatic span(input int got, input int lo, input int hi);
      n_compared++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("[FAIL] %0t off span %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask : span
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] q;
      sm.xfer({1'b1, a, d}, q);
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [15:0] q);
      sm.xfer({1'b0, a, 16'h0000}, q);
   endtask : rd
   // Brief over-current, then count low cycles up to lim
   task automatic trip(input int ch, input int lim, output int n);
      n = 0;
      @(negedge clk) overcurrent_in[ch] = 1'b1;
      while (outs_w[ch] && n < 20) begin
         @(negedge clk);
         n++;
      end
      overcurrent_in[ch] = 1'b0;
      n = 0;
      while (!outs_w[ch] && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : trip
   task automatic test_done;
      $display("mismatches %0d compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   // Watchdog sized well past the roughly 11k-cycle run
   initial begin
      #200000;
      mismatches++;
      test_done();
   end
   initial begin
      logic [15:0] q;
      int n;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      foreach (rows[k]) begin
         wr(A_EC, rows[k].data);
         chk({6'h00, ec_reference_code, ec_target_zero, highside_ten, ec_gate_drive_pin,
            ec_fast_discharge_switch}, {6'h00, rows[k].outs});
         rd(A_EC, q);
         chk(q, rows[k].data);
      end
      // Full-scale select, then an unmapped read
      wr(A_RC, 16'h0001);
      chk({15'h0000, ec_full_scale_select}, 16'h0001);
      rd(7'h7f, q);
      chk(q, 16'h0000);
      // Output one recovers, long then short off time
      wr(A_RC, 16'h8000);
      bridge_request = 3'h7;
      // Outputs need two clocks to follow the request before a fault can trip them
      repeat (4) @(negedge clk);
      chk({13'h0000, bridge_output_three, bridge_output_two, bridge_output_one}, 16'h0007);
      trip(0, 3 * OFF, n);
      span(n, OFF - 1, OFF + 4);
      duty_select = 1'b1;
      trip(0, 3 * SHORT, n);
      span(n, SHORT - 1, SHORT + 4);
      duty_select = 1'b0;
      // Output two has recovery off: stays off until request drops
      trip(1, 3 * OFF, n);
      span(n, 3 * OFF, 3 * OFF);
      bridge_request = 3'h5;
      repeat (4) @(negedge clk);
      bridge_request = 3'h7;
      repeat (6) @(negedge clk);
      chk({15'h0000, bridge_output_two}, 16'h0001);
      // Lowside recovers outside mirror mode, not inside it
      wr(A_RC, 16'h0200);
      wr(A_EC, 16'h0100);
      trip(3, 3 * OFF, n);
      span(n, OFF - 1, OFF + 4);
      wr(A_EC, 16'h0102);
      trip(3, 3 * OFF, n);
      span(n, 3 * OFF, 3 * OFF);
      chk({12'h000, overcurrent_flags}, 16'h000b);
      wr(ec_ocr_pkg::OVERCURRENT_STATUS_ADDR, 16'h000f);
      chk({12'h000, overcurrent_flags}, 16'h0000);
      // Frozen clock enable: a frame sent now is never seen, mode stays on
      clk_en = 1'b0;
      wr(A_EC, 16'h0000);
      clk_en = 1'b1;
      repeat (4) @(negedge clk);
      chk({14'h0000, highside_ten, ec_gate_drive_pin}, 16'h0003);
      // Second reset in mid-run
      wr(A_EC, 16'h04fc);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      chk({6'h00, ec_reference_code, ec_target_zero, highside_ten, ec_gate_drive_pin,
         ec_fast_discharge_switch}, 16'h0008);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      rd(A_EC, q);
      chk(q, 16'h0000);
      rd(A_RC, q);
      chk(q, 16'h0000);
      test_done();
   end
endmodule : ec_mirror_and_ocr_control_bench
`default_nettype wire
